// File: ecp_link_pkg.sv
package ecp_link_pkg;
    // port word width and shared fifo depth
    localparam int WORD_W      = 8;
    localparam int FIFO_DEPTH  = 16;
    localparam int FIFO_AW     = 4;
    // transfer buffer in front of the shared fifo
    localparam int BUF_DEPTH   = 32;
    localparam int BUF_AW      = 5;
    // port mode field encodings
    localparam logic [2:0] MODE_SPP     = 3'h0;
    localparam logic [2:0] MODE_PS2     = 3'h1;
    localparam logic [2:0] MODE_PPFIFO  = 3'h2;
    localparam logic [2:0] MODE_ECP     = 3'h3;
    // command byte layout: bit 7 set means channel address
    localparam int CMD_ADDR_BIT = 7;
    localparam logic [6:0] RLE_CNT_W0 = 7'h00;
    // reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic       PIN_IDLE = 1'b1;
    // a fifo entry: byte plus command tag
    typedef struct packed {
        logic       cmd;
        logic [7:0] data;
    } tagged_byte_t;
    localparam int TAGGED_W = 9;
endpackage

// File: ecp_parallel_port_link.sv
`timescale 1ns/1ps
`default_nettype none

// generic fifo with valid/ready on both sides
module ecp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem [DEPTH];      // storage array
    logic [AW-1:0]    wr_r;             // write pointer
    logic [AW-1:0]    rd_r;             // read pointer
    logic [AW:0]      cnt_r;            // occupancy
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rd_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    // pointers and count; flush empties the fifo on a direction change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else if (flush) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= AW'(wr_r + 1'b1);
            end
            if (pop) begin
                rd_r <= AW'(rd_r + 1'b1);
            end
            cnt_r <= (AW+1)'(cnt_r + push - pop);
        end
    end
endmodule

module ecp_parallel_port_link (
    input  wire logic                       CLK_SYS,
    input  wire logic                       RST_N,
    input  wire logic [2:0]                 MODE,
    input  wire logic                       DIRECTION,
    input  wire ecp_link_pkg::tagged_byte_t WR_BYTE,
    input  wire logic                       WR_VALID,
    output logic                            WR_READY,
    output ecp_link_pkg::tagged_byte_t      RD_BYTE,
    output logic                            RD_VALID,
    input  wire logic                       RD_READY,
    output logic                            DMA_REQ,
    output logic                            FAULT_ERR,
    output logic                            PERIPH_REQ_HINT,
    output logic [7:0]                      PDATA_O,
    output logic                            PDATA_OE_N,
    input  wire logic [7:0]                 PDATA_I,
    output logic                            NSTROBE,
    output logic                            NAUTOFD,
    output logic                            NINIT,
    output logic                            NSELECTIN,
    input  wire logic                       NACK,
    input  wire logic                       BUSY,
    input  wire logic                       PERROR,
    input  wire logic                       NFAULT
);
    // two-flop synchronisers for all peripheral pins
    logic [11:0] pin_s1_r;
    logic [11:0] pin_s2_r;
    logic [7:0]  pd_s;
    logic        nack_s;
    logic        busy_s;
    logic        perr_s;
    logic        nfault_s;

    // link state
    typedef enum logic [2:0] {
        S_IDLE, S_FWD_SETUP, S_FWD_STROBE, S_FWD_RELEASE,
        S_TURN_REV, S_REV_WAIT, S_REV_ACK, S_TURN_FWD
    } link_state_t;
    link_state_t state_r;

    logic                      ecp_mode;    // engine enabled
    logic                      ppfifo_mode; // compatibility fifo mode
    logic                      rev_dir;     // requested direction
    logic                      is_rev_r;    // link currently reverse
    ecp_link_pkg::tagged_byte_t tx_r;       // byte being sent
    logic [6:0]                rle_r;       // pending repeat count
    logic                      rle_pend_r;  // count seen, next byte repeats
    ecp_link_pkg::tagged_byte_t rx_r;       // byte being delivered
    logic                      rx_valid_r;  // rx_r holds a byte
    logic [6:0]                rep_r;       // copies still to deliver

    // shared 16-byte fifo signals
    ecp_link_pkg::tagged_byte_t sf_in;
    logic                      sf_in_valid;
    logic                      sf_in_ready;
    ecp_link_pkg::tagged_byte_t sf_out;
    logic                      sf_out_valid;
    logic                      sf_out_ready;
    // 32-word transfer buffer signals
    ecp_link_pkg::tagged_byte_t bf_out;
    logic                      bf_out_valid;
    logic                      bf_out_ready;
    logic                      bf_in_ready;
    logic                      bf_in_valid;
    logic                      flush;

    assign pd_s     = pin_s2_r[7:0];
    assign nack_s   = pin_s2_r[8];
    assign busy_s   = pin_s2_r[9];
    assign perr_s   = pin_s2_r[10];
    assign nfault_s = pin_s2_r[11];

    assign ecp_mode    = (MODE == ecp_link_pkg::MODE_ECP);
    assign ppfifo_mode = (MODE == ecp_link_pkg::MODE_PPFIFO);
    // ppfifo mode is forward only regardless of the direction bit
    assign rev_dir     = ecp_mode & DIRECTION;
    assign flush       = (state_r == S_TURN_REV) | (state_r == S_TURN_FWD);

    // synchronise the asynchronous peripheral inputs
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end else begin
            pin_s1_r <= {NFAULT, PERROR, BUSY, NACK, PDATA_I};
            pin_s2_r <= pin_s1_r;
        end
    end

    // forward path: host writes -> 32-word buffer -> shared fifo -> link.
    // in reverse the buffer is the receive side instead.
    // a write counts only when ready was shown, so a held request is not taken twice
    assign bf_in_valid = is_rev_r ? rx_valid_r : WR_VALID & WR_READY & ~rev_dir;
    ecp_fifo #(
        .WIDTH (ecp_link_pkg::TAGGED_W),
        .DEPTH (ecp_link_pkg::BUF_DEPTH),
        .AW    (ecp_link_pkg::BUF_AW)
    ) u_buf (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .flush     (flush),
        .in_data   (is_rev_r ? rx_r : WR_BYTE),
        .in_valid  (bf_in_valid),
        .in_ready  (bf_in_ready),
        .out_data  (bf_out),
        .out_valid (bf_out_valid),
        .out_ready (bf_out_ready)
    );

    // bytes pass through unaltered: compression is optional and left out
    assign sf_in        = bf_out;
    assign sf_in_valid  = bf_out_valid;
    assign bf_out_ready = sf_in_ready;

    // one shared fifo serves both directions; it is flushed at turnaround
    ecp_fifo #(
        .WIDTH (ecp_link_pkg::TAGGED_W),
        .DEPTH (ecp_link_pkg::FIFO_DEPTH),
        .AW    (ecp_link_pkg::FIFO_AW)
    ) u_shared (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .flush     (flush),
        .in_data   (sf_in),
        .in_valid  (sf_in_valid),
        .in_ready  (sf_in_ready),
        .out_data  (sf_out),
        .out_valid (sf_out_valid),
        .out_ready (sf_out_ready)
    );

    // forward drain: link engine pops in idle; reverse drain: host reads
    assign sf_out_ready = is_rev_r ? (~RD_VALID | RD_READY)
                                   : (state_r == S_IDLE) & (ecp_mode | ppfifo_mode) & ~rev_dir;

    // link state machine with automatic handshakes
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_r  <= S_IDLE;
            is_rev_r <= 1'b0;
            tx_r     <= '0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (rev_dir & ~is_rev_r) begin
                        state_r <= S_TURN_REV;
                    end else if (~rev_dir & is_rev_r) begin
                        state_r <= S_TURN_FWD;
                    end else if (is_rev_r) begin
                        state_r <= S_REV_WAIT;
                    end else if (sf_out_valid & sf_out_ready) begin
                        tx_r    <= sf_out;
                        state_r <= S_FWD_SETUP;
                    end
                end
                // byte and tag on the bus; wait until peripheral ready
                S_FWD_SETUP: begin
                    if (!busy_s) begin
                        state_r <= S_FWD_STROBE;
                    end
                end
                // strobe asserted; peripheral raises busy when latched
                S_FWD_STROBE: begin
                    if (busy_s) begin
                        state_r <= S_FWD_RELEASE;
                    end
                end
                // strobe released; hardware toggles it, software never does
                S_FWD_RELEASE: begin
                    state_r <= S_IDLE;
                end
                // data released first, then ninit low; wait nackreverse low
                S_TURN_REV: begin
                    if (!perr_s) begin
                        is_rev_r <= 1'b1;
                        state_r  <= S_IDLE;
                    end
                end
                // hostack asserted; wait for peripheral ack low
                S_REV_WAIT: begin
                    if (!rev_dir) begin
                        state_r <= S_IDLE;
                    end else if (!nack_s & ~rx_valid_r & rep_r == '0) begin
                        state_r <= S_REV_ACK;
                    end
                end
                // hostack released; wait ack high to close the interlock
                S_REV_ACK: begin
                    if (nack_s) begin
                        state_r <= S_IDLE;
                    end
                end
                // ninit high again; do not drive until nackreverse high
                S_TURN_FWD: begin
                    if (perr_s) begin
                        is_rev_r <= 1'b0;
                        state_r  <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // reverse receive with rle decompression; count bytes are swallowed
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rx_r       <= '0;
            rx_valid_r <= 1'b0;
            rep_r      <= ecp_link_pkg::RLE_CNT_W0;
            rle_r      <= ecp_link_pkg::RLE_CNT_W0;
            rle_pend_r <= 1'b0;
        end else if (flush) begin
            rx_valid_r <= 1'b0;
            rep_r      <= ecp_link_pkg::RLE_CNT_W0;
            rle_pend_r <= 1'b0;
        end else if (rx_valid_r) begin
            // repeat the held byte until its count is used up
            if (bf_in_ready) begin
                if (rep_r == ecp_link_pkg::RLE_CNT_W0) begin
                    rx_valid_r <= 1'b0;
                end else begin
                    rep_r <= 7'(rep_r - 1'b1);
                end
            end
        end else if (state_r == S_REV_WAIT && !nack_s && rep_r == '0) begin
            // periphack high marks a data byte, low a command byte
            if (!busy_s && !pd_s[ecp_link_pkg::CMD_ADDR_BIT]) begin
                rle_r      <= pd_s[6:0];
                rle_pend_r <= 1'b1;
            end else begin
                rx_r.cmd   <= ~busy_s;
                rx_r.data  <= pd_s;
                rx_valid_r <= 1'b1;
                rep_r      <= rle_pend_r & busy_s ? rle_r : ecp_link_pkg::RLE_CNT_W0;
                rle_pend_r <= 1'b0;
            end
        end
    end

    // host-facing read port and flow control, all registered
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RD_BYTE  <= '0;
            RD_VALID <= 1'b0;
            WR_READY <= 1'b0;
            DMA_REQ  <= 1'b0;
        end else begin
            if (is_rev_r & sf_out_valid & sf_out_ready) begin
                RD_BYTE  <= sf_out;
                RD_VALID <= 1'b1;
            end else if (RD_READY | ~is_rev_r) begin
                RD_VALID <= 1'b0;
            end
            WR_READY <= bf_in_ready & ~is_rev_r & ~rev_dir & ~(WR_VALID & WR_READY);
            // dma service in both directions, no negotiation done here
            DMA_REQ  <= ecp_mode & (is_rev_r ? sf_out_valid : bf_in_ready);
        end
    end

    // peripheral status: nfault only counts while forward
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            FAULT_ERR       <= 1'b0;
            PERIPH_REQ_HINT <= 1'b0;
        end else begin
            FAULT_ERR       <= ~nfault_s & ~is_rev_r;
            // only a hint; direction stays under host control
            PERIPH_REQ_HINT <= ~nfault_s & ~is_rev_r & ecp_mode;
        end
    end

    // link pin drivers, all from flip-flops
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PDATA_O    <= ecp_link_pkg::DATA_RST;
            PDATA_OE_N <= ecp_link_pkg::PIN_IDLE;
            NSTROBE    <= ecp_link_pkg::PIN_IDLE;
            NAUTOFD    <= ecp_link_pkg::PIN_IDLE;
            NINIT      <= ecp_link_pkg::PIN_IDLE;
            NSELECTIN  <= ecp_link_pkg::PIN_IDLE;
        end else begin
            PDATA_O    <= tx_r.data;
            // drive only while forward and nackreverse high
            PDATA_OE_N <= ~(~is_rev_r & perr_s & ~rev_dir &
                            state_r != S_TURN_FWD);
            NSTROBE    <= ~(state_r == S_FWD_STROBE);
            // forward: hostack low tags a command; reverse: low requests
            NAUTOFD    <= is_rev_r ? ~(state_r == S_REV_WAIT)
                                   : ~(ecp_mode & tx_r.cmd);
            // ninit falls only after the data enable has been released,
            // and rises on the way back so the far side can grant forward
            NINIT      <= ~((is_rev_r & (state_r != S_TURN_FWD)) |
                            (state_r == S_TURN_REV & PDATA_OE_N));
            NSELECTIN  <= ~ppfifo_mode & ~(MODE == ecp_link_pkg::MODE_SPP);
        end
    end
endmodule

`default_nettype wire

// File: ecp_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
// watches the link pins from the top ports only
module ecp_link_checker (
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic [2:0] MODE,
    input wire logic       DIRECTION,
    input wire logic       WR_READY,
    input wire logic       FAULT_ERR,
    input wire logic       PDATA_OE_N,
    input wire logic       NSTROBE,
    input wire logic       NAUTOFD,
    input wire logic       NINIT,
    input wire logic       NSELECTIN,
    input wire logic       NACK,
    input wire logic       BUSY,
    input wire logic       PERROR,
    input wire logic       NFAULT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // selector stays deasserted while the ecp engine runs
    property p_sel_idle; (MODE == ecp_link_pkg::MODE_ECP)[*3] |-> NSELECTIN; endproperty
    a_sel_idle: assert property (p_sel_idle)
        else $error("selector asserted in ecp mode");
    // address and data writes refused while reversed
    property p_wr_rev; (DIRECTION && MODE == ecp_link_pkg::MODE_ECP)[*2] |-> !WR_READY; endproperty
    a_wr_rev: assert property (p_wr_rev)
        else $error("write accepted in reverse");
    // host drives data only while the far side grants forward
    property p_oe_grant; !PDATA_OE_N |-> PERROR; endproperty
    a_oe_grant: assert property (p_oe_grant)
        else $error("data driven without forward grant");
    // data lines released before the reverse request
    property p_ninit_fall; $fell(NINIT) |-> PDATA_OE_N && $past(PDATA_OE_N); endproperty
    a_ninit_fall: assert property (p_ninit_fall)
        else $error("reverse request while driving data");
    // strobe only after busy low has been seen through the synchroniser
    property p_strobe_wait; $fell(NSTROBE) |-> !$past(BUSY, 1) && !$past(BUSY, 2); endproperty
    a_strobe_wait: assert property (p_strobe_wait)
        else $error("strobe while peripheral busy");
    // strobe released only once the peripheral has acknowledged
    property p_strobe_rel; $rose(NSTROBE) |-> $past(BUSY, 1) && $past(BUSY, 2); endproperty
    a_strobe_rel: assert property (p_strobe_rel)
        else $error("strobe released before busy");
    // reverse request withdrawn only after the byte was marked valid
    property p_rev_ack;
        $rose(NAUTOFD) && DIRECTION && !NINIT && $past(NINIT, 3) == 1'b0 |-> !$past(NACK, 1) && !$past(NACK, 2);
    endproperty
    a_rev_ack: assert property (p_rev_ack)
        else $error("host ack released before nack");
    // direction pin follows the requested direction within eight cycles
    property p_dir; (MODE == ecp_link_pkg::MODE_ECP && $stable(DIRECTION))[*8] |-> NINIT == !DIRECTION; endproperty
    a_dir: assert property (p_dir)
        else $error("direction pin wrong");
    // fault input flags an error in forward and is ignored in reverse
    property p_fault_fwd;
        (!NFAULT && !DIRECTION && NINIT && PERROR && MODE == ecp_link_pkg::MODE_ECP)[*5] |-> FAULT_ERR;
    endproperty
    a_fault_fwd: assert property (p_fault_fwd)
        else $error("fault not flagged");
    property p_fault_rev; (!NINIT)[*4] |-> !FAULT_ERR; endproperty
    a_fault_rev: assert property (p_fault_rev)
        else $error("fault flagged in reverse");
    c_fwd: cover property ($fell(NSTROBE));
    c_rev: cover property (!NINIT && $fell(NACK));
    c_fault: cover property ($rose(FAULT_ERR));
endmodule
bind ecp_parallel_port_link ecp_link_checker ecp_link_checker_inst (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .MODE(MODE), .DIRECTION(DIRECTION), .WR_READY(WR_READY),
    .FAULT_ERR(FAULT_ERR), .PDATA_OE_N(PDATA_OE_N), .NSTROBE(NSTROBE), .NAUTOFD(NAUTOFD), .NINIT(NINIT),
    .NSELECTIN(NSELECTIN), .NACK(NACK), .BUSY(BUSY), .PERROR(PERROR), .NFAULT(NFAULT)
);
`default_nettype wire

// File: ecp_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural peripheral on the far side of the link
module ecp_periph_model (
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire logic       fault,
    input  wire logic [7:0] pdata_o,
    input  wire logic       nautofd,
    input  wire logic       nstrobe,
    input  wire logic       ninit,
    input  wire logic       nselectin,
    output logic            nack,
    output logic            busy,
    output logic            perror,
    output logic [7:0]      pdata_i,
    output logic            nfault
);
    logic [8:0]                 fwd_q[$];    // {host ack level, byte} as latched
    ecp_link_pkg::tagged_byte_t rev_q[$];    // bytes queued for reverse
    logic                       busy_f = 1'b1;
    logic                       busy_r = 1'b1;
    // busy means flow control forward and the command tag in reverse
    assign busy = ninit ? busy_f : busy_r;
    assign nfault = ~fault;
    initial begin
        nack = 1'b1;
        pdata_i = 8'h00;
        perror = 1'b1;
    end
    // grant follows the direction pin after a settling delay
    always @(ninit) perror <= #20 ninit;
    // forward: flag ready, latch on strobe, hold busy until strobe returns
    always begin
        while (stall || !ninit) @(posedge clk);
        #1 busy_f = 1'b0;
        @(negedge nstrobe);
        fwd_q.push_back({nautofd, pdata_o});
        #3 busy_f = 1'b1;
        @(posedge nstrobe);
        @(posedge clk);
    end
    // reverse: one byte per host request, lines turned over after release
    always begin
        while (ninit || perror || nautofd || !nselectin || rev_q.size() == 0) @(posedge clk);
        #1 pdata_i = rev_q[0].data;
        busy_r = ~rev_q[0].cmd;
        #8 nack = 1'b0;
        while (!nautofd) @(posedge clk);
        #1 pdata_i = ~rev_q[0].data;
        nack = 1'b1;
        void'(rev_q.pop_front());
        @(posedge clk);
    end
endmodule
`default_nettype wire

// File: tb_ecp_parallel_port_link.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ecp_parallel_port_link;
    // forward row: byte written beside the host ack level it should carry
    typedef struct packed {
        ecp_link_pkg::tagged_byte_t b;
        logic                       hostack;
    } row_t;
    row_t rows[5] = '{'{'{1'b1, 8'h85}, 1'b0}, '{'{1'b1, 8'h04}, 1'b0}, '{'{1'b0, 8'h00}, 1'b1},
                      '{'{1'b0, 8'hff}, 1'b1}, '{'{1'b0, 8'h5a}, 1'b1}};
    // reverse stream expected after decompression of a count of two
    ecp_link_pkg::tagged_byte_t exp_r[5] = '{'{1'b0, 8'h7e}, '{1'b0, 8'h7e}, '{1'b0, 8'h7e},
                                            '{1'b1, 8'h85}, '{1'b0, 8'h11}};
    logic                       clk_sys = 1'b0;
    logic                       rst_n = 1'b0;
    logic [2:0]                 mode = ecp_link_pkg::MODE_ECP;
    logic                       direction = 1'b0;
    ecp_link_pkg::tagged_byte_t wr_byte = '0;
    logic                       wr_valid = 1'b0;
    logic                       rd_ready = 1'b0;
    logic                       stall = 1'b0;
    logic                       fault = 1'b0;
    logic                       wr_ready, rd_valid, dma_req, fault_err, hint, oe_n;
    logic                       nstrobe, nautofd, ninit, nselectin, nack, busy, perror, nfault, ok;
    logic [7:0]                 pdata_o, pdata_i;
    ecp_link_pkg::tagged_byte_t rd_byte, got, wb;
    int                         mismatches = 0;
    int                         checks = 0;
    int                         acc;
    always #4 clk_sys = ~clk_sys;
    ecp_periph_model periph (.clk(clk_sys), .stall(stall), .fault(fault), .pdata_o(pdata_o), .nautofd(nautofd),
        .nstrobe(nstrobe), .ninit(ninit), .nselectin(nselectin), .nack(nack), .busy(busy), .perror(perror),
        .pdata_i(pdata_i), .nfault(nfault));
    ecp_parallel_port_link ecp_parallel_port_link_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .MODE(mode),
        .DIRECTION(direction), .WR_BYTE(wr_byte), .WR_VALID(wr_valid), .WR_READY(wr_ready), .RD_BYTE(rd_byte),
        .RD_VALID(rd_valid), .RD_READY(rd_ready), .DMA_REQ(dma_req), .FAULT_ERR(fault_err),
        .PERIPH_REQ_HINT(hint), .PDATA_O(pdata_o), .PDATA_OE_N(oe_n), .PDATA_I(pdata_i), .NSTROBE(nstrobe),
        .NAUTOFD(nautofd), .NINIT(ninit), .NSELECTIN(nselectin), .NACK(nack), .BUSY(busy), .PERROR(perror),
        .NFAULT(nfault));
    // single comparison point, four-state exact
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // holds the write until accepted; on timeout the request stays up
    task automatic wr(input ecp_link_pkg::tagged_byte_t b, input int lim, output logic acc_ok);
        int n;
        n = 0;
        @(negedge clk_sys);
        wr_byte = b;
        wr_valid = 1'b1;
        while (wr_ready !== 1'b1 && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        acc_ok = (n < lim);
        if (acc_ok) begin
            @(negedge clk_sys);
            wr_valid = 1'b0;
        end
    endtask
    task automatic rd(output ecp_link_pkg::tagged_byte_t b);
        int n;
        n = 0;
        @(negedge clk_sys);
        rd_ready = 1'b1;
        while (rd_valid !== 1'b1 && n < 500) begin
            @(negedge clk_sys);
            n++;
        end
        b = rd_byte;
        @(negedge clk_sys);
        rd_ready = 1'b0;
    endtask
    // bounded wait for the peripheral to have latched n bytes
    task automatic wait_fwd(input int n);
        int k;
        k = 0;
        while (periph.fwd_q.size() < n && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
    endtask
    task automatic reset_check;
        check("pins_idle", {12'h0, nstrobe, nautofd, ninit, nselectin}, 16'h000f);
        check("pdata_o", {8'h0, pdata_o}, 16'h0000);
        check("outs_low", {12'h0, rd_valid, dma_req, fault_err, hint}, 16'h0000);
    endtask
    // watchdog sized well beyond the expected run
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        reset_check();
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        foreach (rows[i]) begin
            wr(rows[i].b, 200, ok);
            wait_fwd(i + 1);
            check("fwd_byte", {7'h0, periph.fwd_q[i]}, {7'h0, rows[i].hostack, rows[i].b.data});
        end
        // stall the far side until the path refuses, then drain in order
        stall = 1'b1;
        acc = 0;
        ok = 1'b1;
        while (ok && acc < 80) begin
            wb = '{1'b0, 8'(acc)};
            wr(wb, 8, ok);
            if (ok) acc++;
        end
        check("dma_full", {15'h0, dma_req}, 16'h0);
        // one byte held at the link, the shared fifo and the buffer all full
        check("fill_depth", 16'(acc), 16'(ecp_link_pkg::BUF_DEPTH + ecp_link_pkg::FIFO_DEPTH + 1));
        stall = 1'b0;
        wr(wb, 2000, ok);
        acc++;
        wait_fwd(5 + acc);
        for (int i = 0; i < acc; i++) check("fill_order", {7'h0, periph.fwd_q[5 + i]}, {8'h01, 8'(i)});
        check("dma_room", {15'h0, dma_req}, 16'h1);
        // reverse: count byte, repeated data, an address, plain data
        periph.rev_q = '{'{1'b1, 8'h02}, '{1'b0, 8'h7e}, '{1'b1, 8'h85}, '{1'b0, 8'h11}};
        direction = 1'b1;
        repeat (10) @(negedge clk_sys);
        check("turn_rev", {13'h0, ninit, oe_n, wr_ready}, 16'h0002);
        foreach (exp_r[i]) begin
            rd(got);
            check("rev_byte", {7'h0, got}, {7'h0, exp_r[i]});
        end
        repeat (20) @(negedge clk_sys);
        check("rev_extra", {15'h0, rd_valid}, 16'h0);
        fault = 1'b1;
        repeat (6) @(negedge clk_sys);
        check("fault_rev", {15'h0, fault_err}, 16'h0);
        direction = 1'b0;
        repeat (12) @(negedge clk_sys);
        check("turn_fwd", {14'h0, ninit, oe_n}, 16'h0002);
        check("fault_fwd", {14'h0, fault_err, hint}, 16'h0003);
        fault = 1'b0;
        // compatibility fifo mode uses the same automatic handshake
        @(negedge clk_sys);
        mode = ecp_link_pkg::MODE_PPFIFO;
        wb = '{1'b0, 8'hc3};
        wr(wb, 200, ok);
        wait_fwd(6 + acc);
        check("compat_byte", {8'h0, periph.fwd_q[5 + acc][7:0]}, 16'h00c3);
        // outside ecp the engine ignores the direction request
        mode = ecp_link_pkg::MODE_SPP;
        direction = 1'b1;
        repeat (8) @(negedge clk_sys);
        check("spp_idle", {14'h0, ninit, dma_req}, 16'h0002);
        direction = 1'b0;
        mode = ecp_link_pkg::MODE_ECP;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b0;
        @(negedge clk_sys);
        reset_check();
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        report_and_stop();
    end
endmodule
`default_nettype wire
